// ===== hdl/hpas_pkg.sv
/*
 * Shared types and constants of the host port access sequencer.
 * Assumes a single 100 MHz expansion bus clock for every count.
 */
package hpas_pkg;

	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned CNT_W  = 5;

	// Clock period in ns; every phase is a whole number of these cycles
	localparam int unsigned CLK_PERIOD_NS = 10;

	// Least programmed counts that keep the ready-wait handling safe
	localparam logic [1:0] ADDR_CNT_MIN   = 2'h2;
	localparam logic [1:0] SETUP_CNT_MIN  = 2'h2;
	localparam logic [3:0] STROBE_CNT_MIN = 4'h1;

	// Recovery counts to its count plus this many, so lasts count plus two cycles (2 to 17)
	localparam logic [CNT_W-1:0] REC_EXTRA = 5'h01;
	localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;

	// Byte mode uses the low data lane only
	localparam logic [DATA_W-1:0] BYTE_MASK = 16'h00FF;

	typedef enum logic [2:0] {
		HPAS_IDLE   = 3'h0,
		HPAS_ADDR   = 3'h1,
		HPAS_SETUP  = 3'h2,
		HPAS_STROBE = 3'h3,
		HPAS_HOLD   = 3'h4,
		HPAS_RECOV  = 3'h5
	} hpas_state_t;

	typedef struct packed {
		logic [1:0] address_phase_count;
		logic [1:0] setup_phase_count;
		logic [3:0] strobe_phase_count;
		logic [1:0] hold_phase_count;
		logic [3:0] recovery_phase_count;
	} hpas_cfg_t;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} hpas_req_t;

endpackage : hpas_pkg

// ===== hdl/hpas_sync.sv
/*
 * Two flip-flop synchroniser for pin inputs.
 * Assumes the inputs are asynchronous to clock_i.
 */
`timescale 1ns/1ps
`default_nettype none

module hpas_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clock_i,
	input  wire logic             resetn_i,
	input  wire logic [WIDTH-1:0] async_i,
	output var  logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;

	// First stage is read only by the second
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule : hpas_sync

`default_nettype wire

// ===== hdl/hpas_top.sv
/*
 * Host port access sequencer: runs one access to an external DSP host port
 * through address, setup, strobe, hold and recovery phases.
 * Assumes the requester holds req_i until ready_o and a DSP that drives
 * host_ready_wait_i high while it needs the access stretched.
 */
`timescale 1ns/1ps
`default_nettype none

module hpas_top
	import hpas_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic              resetn_i,
	input  wire hpas_cfg_t         cfg_i,
	input  wire logic              host_port_halfword_mode_i,
	input  wire logic              req_i,
	input  wire hpas_req_t         req_data_i,
	output var  logic              ready_o,
	output var  logic              busy_o,
	output var  logic              done_o,
	output var  logic [DATA_W-1:0] rdata_o,
	input  wire logic              host_ready_wait_i,
	input  wire logic [DATA_W-1:0] host_data_i,
	output var  logic [DATA_W-1:0] host_data_o,
	output var  logic              host_data_oe_o,
	output var  logic [ADDR_W-1:0] host_addr_o,
	output var  logic              host_cs_n_o,
	output var  logic              host_data_strobe_n_o
);

	logic              wait_s;
	logic [DATA_W-1:0] data_s;

	hpas_sync #(.WIDTH(DATA_W + 1)) u_sync (
		.clock_i  (clock_i),
		.resetn_i (resetn_i),
		.async_i  ({host_ready_wait_i, host_data_i}),
		.sync_o   ({wait_s, data_s})
	);

	hpas_state_t       state_q,  state_d;
	logic [CNT_W-1:0]  cnt_q,    cnt_d;
	logic              ext_q,    ext_d;
	hpas_req_t         cur_q,    cur_d;
	logic              half_q,   half_d;
	logic [CNT_W-1:0]  last_cnt;
	logic              stretch;
	logic              advance;
	logic [1:0]        addr_eff, setup_eff;
	logic [3:0]        strobe_eff;

	always_comb begin
		addr_eff   = (cfg_i.address_phase_count < ADDR_CNT_MIN) ? ADDR_CNT_MIN : cfg_i.address_phase_count;
		setup_eff  = (cfg_i.setup_phase_count < SETUP_CNT_MIN) ? SETUP_CNT_MIN : cfg_i.setup_phase_count;
		strobe_eff = (cfg_i.strobe_phase_count < STROBE_CNT_MIN) ? STROBE_CNT_MIN : cfg_i.strobe_phase_count;
	end

	always_comb begin
		case (state_q)
			HPAS_ADDR:   last_cnt = {3'h0, addr_eff};
			HPAS_SETUP:  last_cnt = {3'h0, setup_eff};
			HPAS_STROBE: last_cnt = {1'h0, strobe_eff};
			HPAS_HOLD:   last_cnt = {3'h0, cfg_i.hold_phase_count};
			HPAS_RECOV:  last_cnt = {1'h0, cfg_i.recovery_phase_count} + REC_EXTRA;
			default:     last_cnt = CNT_ZERO;
		endcase
	end

	assign stretch = (state_q == HPAS_ADDR) || (state_q == HPAS_SETUP) || (state_q == HPAS_STROBE);

	// wait holds the phase, then one extra clock
	always_comb begin
		ext_d   = ext_q;
		advance = 1'b0;
		if (stretch && wait_s) begin
			ext_d = 1'b1;
		end else if (stretch && ext_q) begin
			ext_d = 1'b0;
		end else begin
			advance = (cnt_q == last_cnt);
		end
		if (state_q == HPAS_IDLE) begin
			ext_d = 1'b0;
		end
	end

	// phase sequencing on the bus clock
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		cur_d   = cur_q;
		half_d  = half_q;
		if (state_q == HPAS_IDLE) begin
			if (req_i) begin
				state_d = HPAS_ADDR;
				cnt_d   = CNT_ZERO;
				cur_d   = req_data_i;
				half_d  = host_port_halfword_mode_i;
			end
		end else if (advance) begin
			cnt_d = CNT_ZERO;
			case (state_q)
				HPAS_ADDR:   state_d = HPAS_SETUP;
				HPAS_SETUP:  state_d = HPAS_STROBE;
				HPAS_STROBE: state_d = HPAS_HOLD;
				HPAS_HOLD:   state_d = HPAS_RECOV;
				default:     state_d = HPAS_IDLE;
			endcase
		end else if (!(stretch && (wait_s || ext_q))) begin
			cnt_d = cnt_q + CNT_ONE;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= HPAS_IDLE;
			cnt_q   <= CNT_ZERO;
			ext_q   <= 1'b0;
			cur_q   <= '0;
			half_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			ext_q   <= ext_d;
			cur_q   <= cur_d;
			half_q  <= half_d;
		end
	end

	logic              cs_n_d, strobe_n_d, oe_d, done_d, busy_d, ready_d;
	logic [ADDR_W-1:0] addr_d;
	logic [DATA_W-1:0] wdata_d, rdata_d, lane_mask;

	// Pins follow the next state so each flop lines up with its phase
	always_comb begin
		lane_mask  = half_d ? '1 : BYTE_MASK;
		cs_n_d     = !((state_d == HPAS_ADDR) || (state_d == HPAS_SETUP) ||
			(state_d == HPAS_STROBE) || (state_d == HPAS_HOLD));
		addr_d     = cs_n_d ? '0 : cur_d.addr;
		strobe_n_d = (state_d != HPAS_STROBE);
		// write data from select to end of hold
		oe_d       = !cs_n_d && cur_d.write;
		wdata_d    = oe_d ? (cur_d.wdata & lane_mask) : '0;
		busy_d     = (state_d != HPAS_IDLE);
		ready_d    = (state_q == HPAS_IDLE) && req_i;
		done_d     = (state_q == HPAS_HOLD) && advance;
		rdata_d    = rdata_o;
		// capture at the strobe's last cycle
		if ((state_q == HPAS_STROBE) && advance && !cur_q.write) begin
			rdata_d = data_s & (half_q ? '1 : BYTE_MASK);
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			host_cs_n_o          <= 1'b1;
			host_data_strobe_n_o <= 1'b1;
			host_addr_o          <= '0;
			host_data_o          <= '0;
			host_data_oe_o       <= 1'b0;
			rdata_o              <= '0;
			done_o               <= 1'b0;
			busy_o               <= 1'b0;
			ready_o              <= 1'b0;
		end else begin
			host_cs_n_o          <= cs_n_d;
			host_data_strobe_n_o <= strobe_n_d;
			host_addr_o          <= addr_d;
			host_data_o          <= wdata_d;
			host_data_oe_o       <= oe_d;
			rdata_o              <= rdata_d;
			done_o               <= done_d;
			busy_o               <= busy_d;
			ready_o              <= ready_d;
		end
	end

	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	wait_holds_a: assert property (stretch && wait_s |=> state_q == $past(state_q))
		else $error("phase left during ready-wait");

	addr_extra_a: assert property ($fell(wait_s) && state_q == HPAS_ADDR |=> state_q == HPAS_ADDR)
		else $error("address phase not held after wait");

	data_extra_a: assert property ($fell(wait_s) && state_q == HPAS_STROBE |=> state_q == HPAS_STROBE)
		else $error("data phase not held after wait");

	cs_addr_a: assert property ($fell(host_cs_n_o) |-> host_addr_o == cur_q.addr && state_q == HPAS_ADDR)
		else $error("select without address");

	strobe_gap_a: assert property ($fell(host_cs_n_o) |-> host_data_strobe_n_o [*6])
		else $error("strobe too soon after select");

	strobe_phase_a: assert property (!host_data_strobe_n_o |-> state_q == HPAS_STROBE && !host_cs_n_o)
		else $error("strobe outside its phase");

	wdata_rise_a: assert property ($rose(host_data_strobe_n_o) && cur_q.write |-> host_data_oe_o && $stable(host_data_o))
		else $error("write data not valid at strobe rise");

	wdata_hold_a: assert property (state_q == HPAS_HOLD && cur_q.write |-> host_data_oe_o && !host_cs_n_o)
		else $error("write data dropped in hold");

	recov_gap_a: assert property ($rose(host_cs_n_o) |-> host_cs_n_o [*2])
		else $error("recovery shorter than two cycles");

	order_a: assert property (state_q != $past(state_q) && $past(state_q) != HPAS_RECOV |-> state_q == $past(state_q) + 3'h1)
		else $error("phase order broken");

	write_cov: cover property (req_i && ready_o && req_data_i.write ##[1:80] done_o);
	read_cov:  cover property (req_i && ready_o && !req_data_i.write ##[1:80] done_o);
	wait_cov:  cover property (state_q == HPAS_STROBE && wait_s ##1 !wait_s);

endmodule : hpas_top

`default_nettype wire

// ===== testbench/hpas_dsp_model.sv
/* DSP host port model: read data and ready-wait.
   Assumes registered pins from the sequencer. */
`timescale 1ns/1ps
`default_nettype none
module hpas_dsp_model
	import hpas_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic              resetn_i,
	input  wire logic              cs_n_i,
	input  wire logic              strobe_n_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [1:0]        wait_mode_i,
	input  wire logic [3:0]        wait_len_i,
	output var  logic              ready_wait_o,
	output var  logic [DATA_W-1:0] data_o
);
	logic [3:0] cnt_q;
	logic       cs_n_q;
	logic       st_n_q;
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= 4'h0;
			cs_n_q <= 1'b1;
			st_n_q <= 1'b1;
			data_o <= 16'h0000;
		end else begin
			cs_n_q <= cs_n_i;
			st_n_q <= strobe_n_i;
			if ((wait_mode_i == 2'h1 && cs_n_q && !cs_n_i) || (wait_mode_i == 2'h2 && st_n_q && !strobe_n_i))
				cnt_q <= wait_len_i;
			else if (cnt_q != 4'h0)
				cnt_q <= cnt_q - 4'h1;
			data_o <= cs_n_i ? ~data_o : (addr_i ^ 16'hA5C3);
		end
	end
	assign ready_wait_o = (cnt_q != 4'h0);
endmodule : hpas_dsp_model
`default_nettype wire

// ===== testbench/tb_top.sv
/* Self-checking bench for the access sequencer.
   Assumes the DSP model on the pin side. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import hpas_pkg::*;
;
	logic              clock_i = 1'b0;
	logic              resetn_i = 1'b0;
	hpas_cfg_t         cfg = '0;
	logic              hw = 1'b0;
	logic              req = 1'b0;
	hpas_req_t         rq = '0;
	logic [1:0]        wm = 2'h0;
	logic [3:0]        wl = 4'h1;
	logic              rdy, busy, done, wt, oe, cs_n, st_n;
	logic [DATA_W-1:0] rdata, din, dout, d_st, d_hd;
	logic [ADDR_W-1:0] addr, a_st;
	logic              oe_st, dn, cs_p = 1'b1, st_p = 1'b1, b_p = 1'b0;
	int                failures = 0, tests_run = 0, cyc = 0;
	int                t_csf, t_stf, t_str, t_csr, t_bf;

	always #(CLK_PERIOD_NS / 2) clock_i = ~clock_i;

	hpas_top u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .cfg_i(cfg), .host_port_halfword_mode_i(hw),
		.req_i(req), .req_data_i(rq), .ready_o(rdy), .busy_o(busy), .done_o(done), .rdata_o(rdata),
		.host_ready_wait_i(wt), .host_data_i(din), .host_data_o(dout), .host_data_oe_o(oe),
		.host_addr_o(addr), .host_cs_n_o(cs_n), .host_data_strobe_n_o(st_n));

	hpas_dsp_model u_dsp (.clock_i(clock_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .strobe_n_i(st_n),
		.addr_i(addr), .wait_mode_i(wm), .wait_len_i(wl), .ready_wait_o(wt), .data_o(din));

	// Edge times of the pins, old values seen at each edge
	always @(posedge clock_i) begin
		cyc++;
		if (cs_p && !cs_n) t_csf = cyc;
		if (st_p && !st_n) begin
			t_stf = cyc;
			a_st  = addr;
			d_st  = dout;
			oe_st = oe;
		end
		if (!st_p && st_n) begin
			t_str = cyc;
			d_hd  = dout;
		end
		if (!cs_p && cs_n) begin
			t_csr = cyc;
			dn    = done;
		end
		if (b_p && !busy) t_bf = cyc;
		cs_p = cs_n;
		st_p = st_n;
		b_p  = busy;
	end

	task automatic stop_test;
		if (failures == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// A stretched span only has to exceed its plain length
	task automatic span(input string nm, input int d, input int e, input bit s);
		check(nm, s ? 32'(d > e) : 32'(d), s ? 32'h1 : 32'(e));
	endtask : span

	function automatic logic [DATA_W-1:0] lane(input logic [DATA_W-1:0] v, input logic h);
		return h ? v : (v & BYTE_MASK);
	endfunction : lane

	task automatic run(input hpas_cfg_t c, input logic [1:0] m, input logic h);
		int n;
		@(posedge clock_i);
		#1;
		cfg = c;
		hw  = h;
		wm  = m;
		wl  = 4'($urandom_range(1, 8));
		rq  = hpas_req_t'({$urandom, $urandom});
		req = 1'b1;
		n   = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		// A request that is never taken counts as a mismatch, not a silent skip
		check("ready", rdy, 32'h1);
		#1 req = 1'b0;
		do begin
			@(posedge clock_i);
			n++;
		end while (busy !== 1'b0 && n < 300);
		#1;
		check("finish", 32'(n < 300), 32'h1);
		span("addr_setup", t_stf - t_csf, c.address_phase_count + c.setup_phase_count + 2, m == 2'h1);
		span("strobe", t_str - t_stf, c.strobe_phase_count + 1, m == 2'h2);
		check("hold", t_csr - t_str, c.hold_phase_count + 1);
		check("recovery", t_bf - t_csr, c.recovery_phase_count + 2);
		check("done", dn, 32'h1);
		check("address", a_st, rq.addr);
		check("drive", oe_st, rq.write);
		if (rq.write) begin
			check("wdata_setup", d_st, lane(rq.wdata, h));
			check("wdata_hold", d_hd, lane(rq.wdata, h));
		end else
			check("rdata", rdata, lane(rq.addr ^ 16'hA5C3, h));
	endtask : run

	initial begin
		hpas_cfg_t c;
		void'($urandom(29874));
		repeat (8) @(posedge clock_i);
		#1 resetn_i = 1'b1;
		run(hpas_cfg_t'{2'h2, 2'h2, 4'h1, 2'h0, 4'h0}, 2'h0, 1'b0);
		run(hpas_cfg_t'{2'h3, 2'h3, 4'hF, 2'h3, 4'hF}, 2'h2, 1'b1);
		for (int i = 0; i < 40; i++) begin
			c = hpas_cfg_t'($urandom);
			c.address_phase_count[1] = 1'b1;
			c.setup_phase_count[1] = 1'b1;
			if (c.strobe_phase_count == 4'h0) c.strobe_phase_count = 4'h1;
			// Strobe long enough that a late wait still lands in it
			if (i % 3 == 2) c.strobe_phase_count[3] = 1'b1;
			run(c, 2'(i % 3), 1'($urandom));
		end
		stop_test();
	end

	initial begin
		repeat (30000) @(posedge clock_i);
		failures++;
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
